// *** logic/tap_pkg.sv ***
// Constants and types shared by the test access port design
`default_nettype none
package tap_pkg;
    localparam int unsigned IR_WIDTH = 4;
    localparam int unsigned DR_WIDTH = 32;
    localparam logic [3:0] IR_RESET = 4'h1;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] INSN_IDCODE = 4'h1;
    localparam logic [3:0] INSN_USERDATA = 4'h2;
    localparam logic [3:0] INSN_BYPASS = 4'hf;
    localparam logic [31:0] ID_VALUE = 32'h00000001; // Arbitrary identification value
    localparam logic [31:0] USER_RESET = 32'h00000000;
    localparam int unsigned RESET_TMS_EDGES = 5;
    localparam int unsigned SYNC_STAGES = 2;

    typedef enum logic [15:0] {
        ST_RESET      = 16'h0001,
        ST_IDLE       = 16'h0002,
        ST_SEL_DR     = 16'h0004,
        ST_CAP_DR     = 16'h0008,
        ST_SH_DR      = 16'h0010,
        ST_EX1_DR     = 16'h0020,
        ST_PAUSE_DR   = 16'h0040,
        ST_EX2_DR     = 16'h0080,
        ST_UPD_DR     = 16'h0100,
        ST_SEL_IR     = 16'h0200,
        ST_CAP_IR     = 16'h0400,
        ST_SH_IR      = 16'h0800,
        ST_EX1_IR     = 16'h1000,
        ST_PAUSE_IR   = 16'h2000,
        ST_EX2_IR     = 16'h4000,
        ST_UPD_IR     = 16'h8000
    } tap_state_t;
endpackage
`default_nettype wire

// *** logic/pin_sync.sv ***
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import tap_pkg::*;
#(
    parameter int unsigned WIDTH = 4
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (ce_i) begin
            st_next.s1 = async_i;
            st_next.s2 = st_reg.s1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_o = st_reg.s2;
endmodule
`default_nettype wire

// *** logic/jtag_tap.sv ***
// Test access port: state machine, instruction and data registers
`timescale 1ns/1ps
`default_nettype none
module jtag_tap
    import tap_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trst_n_i,
    input wire logic [31:0] user_capture_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic [3:0] ir_o,
    output logic [31:0] user_data_o,
    output logic user_update_o,
    output logic tap_reset_o
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [3:0] pins_sync;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic trst_n_s;

    // Flops reset low: tck idles low, test reset reads asserted until synchronised
    pin_sync #(.WIDTH(4)) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .async_i({trst_n_i, tdi_i, tms_i, tck_i}),
        .sync_o(pins_sync)
    );

    assign tck_s = pins_sync[0];
    assign tms_s = pins_sync[1];
    assign tdi_s = pins_sync[2];
    assign trst_n_s = pins_sync[3];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // All port state in one record, registered as a whole
    typedef struct packed {
        tap_state_t state;
        logic tck_d;
        logic [3:0] ir_shift;
        logic [3:0] ir;
        logic [31:0] dr_shift;
        logic [31:0] user;
        logic bypass;
        logic tdo;
        logic oe;
        logic upd;
    } tap_regs_t;

    tap_regs_t r_reg;
    tap_regs_t r_next;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic logic is_shift(input tap_state_t s);
        return (s == ST_SH_DR) || (s == ST_SH_IR);
    endfunction

    function automatic logic is_user(input logic [3:0] insn);
        return insn == INSN_USERDATA;
    endfunction

    // Sixteen-state graph; five high mode bits reach reset from anywhere
    function automatic tap_state_t next_state(input tap_state_t s, input logic m);
        case (s)
            ST_RESET: next_state = m ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: next_state = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = m ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = m ? ST_EX2_DR : ST_PAUSE_DR;
            ST_EX2_DR: next_state = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: next_state = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = m ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = m ? ST_EX2_IR : ST_PAUSE_IR;
            ST_EX2_IR: next_state = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = m ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Test clock edges
    // ------------------------------------------------------------
    // Edges arrive two clocks late; each tck phase must span several clocks
    logic tck_rise;
    logic tck_fall;
    logic dr_lsb;
    // Next state serves both the move and the instruction reset
    tap_state_t nxt_state;

    assign tck_rise = tck_s & ~r_reg.tck_d;
    assign tck_fall = ~tck_s & r_reg.tck_d;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // One pass per clock: test reset first, then rise, then fall
    always_comb begin
        r_next = r_reg;
        r_next.upd = 1'b0;
        dr_lsb = (r_reg.ir == INSN_BYPASS) ? r_reg.bypass : r_reg.dr_shift[0];
        nxt_state = next_state(r_reg.state, tms_s);
        r_next.tck_d = tck_s;
        if (!trst_n_s) begin
            // Test reset overrides both test clock edges, no test clock edge needed
            r_next.state = ST_RESET;
            r_next.ir = IR_RESET;
            r_next.oe = 1'b0;
            r_next.tdo = 1'b0;
        end else if (tck_rise) begin
            r_next.state = nxt_state;
            // Entering the reset state restores the instruction at once
            if (nxt_state == ST_RESET) begin
                r_next.ir = IR_RESET;
            end
            case (r_reg.state)
                ST_CAP_IR: begin
                    // Fixed capture pattern, shifted out first
                    r_next.ir_shift = IR_CAPTURE;
                end
                ST_SH_IR: begin
                    r_next.ir_shift = {tdi_s, r_reg.ir_shift[3:1]};
                end
                ST_UPD_IR: begin
                    r_next.ir = r_reg.ir_shift;
                end
                ST_CAP_DR: begin
                    r_next.bypass = 1'b0;
                    // Unknown instructions capture zero into the full register
                    if (r_reg.ir == INSN_IDCODE) begin
                        r_next.dr_shift = ID_VALUE;
                    end else if (is_user(r_reg.ir)) begin
                        r_next.dr_shift = user_capture_i;
                    end else begin
                        r_next.dr_shift = '0;
                    end
                end
                ST_SH_DR: begin
                    // Bypass stage shifts alongside; only its bit reaches tdo then
                    r_next.bypass = tdi_s;
                    r_next.dr_shift = {tdi_s, r_reg.dr_shift[31:1]};
                end
                ST_UPD_DR: begin
                    if (is_user(r_reg.ir)) begin
                        r_next.user = r_reg.dr_shift;
                        r_next.upd = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (tck_fall) begin
            // Output follows the state reached at the preceding rising edge
            // Registered, so tdo lags the pin fall by three clocks
            r_next.oe = is_shift(r_reg.state);
            if (r_reg.state == ST_SH_IR) begin
                r_next.tdo = r_reg.ir_shift[0];
            end else if (r_reg.state == ST_SH_DR) begin
                r_next.tdo = dr_lsb;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_reg.state <= ST_RESET;
            r_reg.tck_d <= 1'b0;
            r_reg.ir_shift <= IR_CAPTURE;
            r_reg.ir <= IR_RESET;
            r_reg.dr_shift <= '0;
            r_reg.user <= USER_RESET;
            r_reg.bypass <= 1'b0;
            r_reg.tdo <= 1'b0;
            r_reg.oe <= 1'b0;
            r_reg.upd <= 1'b0;
        end else if (ce_i) begin
            // Low enable holds every flop, edge history included
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign tdo_o = r_reg.tdo;
    // Enable low leaves the pin undriven
    assign tdo_oe_o = r_reg.oe;
    assign ir_o = r_reg.ir;
    assign user_data_o = r_reg.user;
    assign user_update_o = r_reg.upd;
    assign tap_reset_o = (r_reg.state == ST_RESET);
endmodule
`default_nettype wire

// *** verification/tap_properties.sv ***
// Checker for the test access port outputs
`timescale 1ns/1ps
`default_nettype none
module tap_properties
    import tap_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic tck_i,
    input wire logic trst_n_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic [3:0] ir_o,
    input wire logic [31:0] user_data_o,
    input wire logic user_update_o,
    input wire logic tap_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence trst_held;
        !trst_n_i [*4];
    endsequence
    sequence in_reset;
        tap_reset_o [*3];
    endsequence
    tdo_on_fall_a: assert property ($changed(tdo_o) |-> !tck_i)
        else $error("tdo moved with tck high");
    oe_on_fall_a: assert property ($changed(tdo_oe_o) |-> !tck_i)
        else $error("oe moved with tck high");
    oe_reset_off_a: assert property (tap_reset_o |-> !tdo_oe_o)
        else $error("oe high in reset state");
    state_on_rise_a: assert property ($changed(tap_reset_o) |-> tck_i || !trst_n_i)
        else $error("state moved off a rise");
    ir_on_rise_a: assert property ($changed(ir_o) |-> tck_i || !trst_n_i)
        else $error("ir moved off a rise");
    trst_forces_a: assert property (trst_held |-> tap_reset_o && ir_o == IR_RESET)
        else $error("test reset not applied");
    reset_ir_a: assert property (in_reset |-> ir_o == IR_RESET)
        else $error("ir not reset in reset state");
    user_load_a: assert property ($changed(user_data_o) |-> user_update_o)
        else $error("user data moved without pulse");
    upd_pulse_a: assert property (user_update_o |=> !user_update_o)
        else $error("update pulse too long");
endmodule
bind jtag_tap tap_properties tap_properties_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .tck_i(tck_i), .trst_n_i(trst_n_i),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .ir_o(ir_o), .user_data_o(user_data_o),
    .user_update_o(user_update_o), .tap_reset_o(tap_reset_o));
`default_nettype wire

// *** verification/ctl_model.sv ***
// Behavioural scan controller driving the test port pins
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
    input wire logic clk_i,
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_n_o
);
    logic q;
    initial {tck_o, tms_o, tdi_o, trst_n_o, q} = 5'h02;
    // Pins change with tck low; a released tdo reads as the previous sample inverted
    task automatic step(input logic m, input logic d);
        @(negedge clk_i);
        tck_o = 1'b0;
        tms_o = m;
        tdi_o = d;
        repeat (4) @(negedge clk_i);
        q = tdo_oe_i ? tdo_i : ~q;
        tck_o = 1'b1;
        repeat (3) @(negedge clk_i);
    endtask
    task automatic go(input int n, input logic [7:0] m);
        for (int i = 0; i < n; i++) step(m[i], 1'b0);
    endtask
    task automatic xfer(input int n, input logic [31:0] di, output logic [31:0] dq);
        dq = 32'h0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, di[i]);
            dq[i] = q;
        end
    endtask
    task automatic trst_pulse;
        @(negedge clk_i);
        tck_o = 1'b0;
        trst_n_o = 1'b0;
        repeat (6) @(negedge clk_i);
        trst_n_o = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the test access port
`timescale 1ns/1ps
`default_nettype none
module tb_top import tap_pkg::*; ;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ce_i = 1'b1;
    logic tck_i, tms_i, tdi_i, trst_n_i, tdo_o, tdo_oe_o, user_update_o, tap_reset_o;
    logic [3:0] ir_o;
    logic [31:0] user_capture_i = 32'h1234_5678;
    logic [31:0] user_data_o, d;
    int miscompares = 0;
    int compares = 0;
    int upds = 0;
    always #12.5 clk_i = ~clk_i;
    always @(negedge clk_i) if (user_update_o === 1'b1) upds++;
    jtag_tap jtag_tap_inst (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .tck_i(tck_i),
        .tms_i(tms_i), .tdi_i(tdi_i), .trst_n_i(trst_n_i), .user_capture_i(user_capture_i),
        .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .ir_o(ir_o), .user_data_o(user_data_o),
        .user_update_o(user_update_o), .tap_reset_o(tap_reset_o));
    ctl_model ctl_model_inst (.clk_i(clk_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o),
        .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .trst_n_o(trst_n_i));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic load_ir(input logic [3:0] v);
        ctl_model_inst.go(4, 8'h03);
        ctl_model_inst.xfer(4, 32'(v), d);
        check("ir capture", d, 32'(IR_CAPTURE));
        ctl_model_inst.go(2, 8'h01);
    endtask
    task automatic read_dr(input int n, input logic [31:0] di);
        ctl_model_inst.go(3, 8'h01);
        ctl_model_inst.xfer(n, di, d);
        ctl_model_inst.go(2, 8'h01);
    endtask
    task automatic t_idcode;
        check("ir", 32'(ir_o), 32'(IR_RESET));
        check("oe", 32'(tdo_oe_o), 32'h0);
        check("user", user_data_o, USER_RESET);
        ctl_model_inst.go(1, 8'h00);
        check("tlr left", 32'(tap_reset_o), 32'h0);
        read_dr(32, 32'h0);
        check("id", d, ID_VALUE);
        check("oe idle", 32'(tdo_oe_o), 32'h0);
    endtask
    task automatic t_user;
        load_ir(INSN_USERDATA);
        check("ir user", 32'(ir_o), 32'(INSN_USERDATA));
        read_dr(32, 32'ha5c3_0f96);
        check("captured", d, user_capture_i);
        check("loaded", user_data_o, 32'ha5c3_0f96);
        @(negedge clk_i);
        check("pulses", 32'(upds), 32'h1);
    endtask
    task automatic t_bypass;
        load_ir(INSN_BYPASS);
        read_dr(8, 32'h96);
        check("bypass", d, 32'h2c);
    endtask
    task automatic t_trst;
        ctl_model_inst.trst_pulse();
        check("ir trst", 32'(ir_o), 32'(IR_RESET));
        check("tlr trst", 32'(tap_reset_o), 32'h1);
    endtask
    task automatic t_ce;
        ce_i = 1'b0;
        ctl_model_inst.go(1, 8'h00);
        check("tlr frozen", 32'(tap_reset_o), 32'h1);
        ce_i = 1'b1;
        repeat (4) @(negedge clk_i);
        check("tlr resumed", 32'(tap_reset_o), 32'h0);
    endtask
    task automatic t_tms;
        ctl_model_inst.go(1, 8'h00);
        load_ir(INSN_USERDATA);
        ctl_model_inst.go(3, 8'h01);
        ctl_model_inst.go(4, 8'h0f);
        check("tlr four", 32'(tap_reset_o), 32'h0);
        ctl_model_inst.go(1, 8'h01);
        check("tlr five", 32'(tap_reset_o), 32'h1);
        check("ir tms", 32'(ir_o), 32'(IR_RESET));
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        @(negedge clk_i) nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        t_idcode();
        t_user();
        t_bypass();
        t_trst();
        t_ce();
        t_tms();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        complete_run();
    end
endmodule
`default_nettype wire
